// File: core/vis_defines.vh
/*
  Vector slots, timer flag bits, sleep codes and cycle counts.
  Assumes inclusion by this block's design files only.
*/
`ifndef VIS_DEFINES_VH
`define VIS_DEFINES_VH

// ----------------------------------------------------------
// vector map: vector address is twice the slot index
// ----------------------------------------------------------
`define VIS_VEC_RESET 16'h0000
`define VIS_IDX_W 6
`define VIS_NUM_SLOTS 36
`define VIS_IDX_ARR0 6'h01
`define VIS_IDX_T2_CMP 6'h09
`define VIS_IDX_T2_OVF 6'h0A
`define VIS_IDX_T1_CAP 6'h0B
`define VIS_IDX_T1_CMPA 6'h0C
`define VIS_IDX_T1_CMPB 6'h0D
`define VIS_IDX_T1_OVF 6'h0E
`define VIS_IDX_T0_CMP 6'h0F
`define VIS_IDX_T0_OVF 6'h10
`define VIS_IDX_ARR4 6'h11
`define VIS_IDX_SER0 6'h15
`define VIS_IDX_ARR8 6'h18
`define VIS_IDX_SER1 6'h1C
`define VIS_IDX_ARR12 6'h1F
`define VIS_IDX_TWI 6'h23

// ----------------------------------------------------------
// timer flag bit positions
// ----------------------------------------------------------
`define VIS_TF_CMP_T0 0
`define VIS_TF_OVF_T0 1
`define VIS_TF_CMP_T2 2
`define VIS_TF_CAP_T1 3
`define VIS_TF_OVF_T2 4
`define VIS_TF_CMPA_T1 5
`define VIS_TF_CMPB_T1 6
`define VIS_TF_OVF_T1 7
`define VIS_COUNT_ZERO 8'h00

// ----------------------------------------------------------
// sleep select {hi,lo}
// ----------------------------------------------------------
`define VIS_SLP_IDLE 2'h0
`define VIS_SLP_PDOWN 2'h2
`define VIS_SLP_PSAVE 2'h3

// ----------------------------------------------------------
// sequence lengths in core cycles
// ----------------------------------------------------------
`define VIS_ENTRY_CYC 3'h4
`define VIS_RETURN_CYC 3'h4
`define VIS_JMP_CYC 2'h3

`endif

// File: core/vis_dispatch.v
/*
  Interrupt dispatch: picks a request, pushes and pops the pc, sleeps, wakes.
  Assumes instr_done_i, reti_i and sleep_instr_i pulses from the core,
  and stack read data one cycle after stack_re_o.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vis_defines.vh"

// How it works
// - reset at 0000; array n at 0002+4n, pin n at 0004+4n.
// - timer vectors 0012 to 0020 in fixed order.
// - array 4..7 at 0022..0028; first serial at 002A..002E.
// - array 8..11, second serial, array 12..15, two-wire 0046.
// - small variant keeps slots of absent array 8..15.
// - capture event sets flag bit 3.
// - timer flag clears on vector entry or write of one.
// - timer request needs global enable, own enable, flag.
// - timer 2 compare match sets flag bit 2.
// - timer 0 overflow sets bit 1; pwm: on leaving zero.
// - timer 0 compare match sets flag bit 0.
// - vector four cycles after take; pc pushed, sp minus two.
// - vector jump takes three cycles.
// - multi-cycle instruction ends before service.
// - return: four cycles, pc popped, sp plus two.
// - one main instruction after return before next service.
// - sleep needs instruction and permit; select picks mode.
// - deep sleep: pin and array 0..3 low-level.
// - wake on enabled interrupt; resume after sleep instruction.
// - reset in sleep wakes to reset vector.
module vis_dispatch #(
  parameter ARRAY_LINES = 16
) (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire global_irq_enable_i,
  input wire [15:0] array_irq_line_i,
  input wire [3:0] pin_irq_line_i,
  input wire serial_rx_done_irq_i,
  input wire serial_tx_empty_irq_i,
  input wire serial_tx_done_irq_i,
  input wire serial1_rx_done_irq_i,
  input wire serial1_tx_empty_irq_i,
  input wire serial1_tx_done_irq_i,
  input wire two_wire_irq_i,
  input wire [7:0] timer_irq_enable_i,
  input wire t0_tick_i,
  input wire [7:0] t0_count_i,
  input wire [7:0] compare_value_t0_i,
  input wire t0_overflow_i,
  input wire t0_pwm_mode_i,
  input wire t2_tick_i,
  input wire [7:0] t2_count_i,
  input wire [7:0] compare_value_t2_i,
  input wire t2_overflow_i,
  input wire t1_capture_i,
  input wire t1_compare_a_i,
  input wire t1_compare_b_i,
  input wire t1_overflow_i,
  input wire flag_write_i,
  input wire [7:0] flag_write_data_i,
  input wire sleep_permit_i,
  input wire sleep_select_hi_i,
  input wire sleep_select_lo_i,
  input wire instr_done_i,
  input wire reti_i,
  input wire sleep_instr_i,
  input wire [15:0] pc_i,
  input wire [15:0] sp_i,
  input wire [7:0] stack_rdata_i,
  output wire [7:0] timer_flags_o,
  output wire core_hold_o,
  output reg stack_we_o,
  output reg stack_re_o,
  output reg [15:0] stack_addr_o,
  output reg [7:0] stack_wdata_o,
  output reg sp_load_o,
  output reg [15:0] sp_o,
  output reg pc_load_o,
  output reg [15:0] pc_o,
  output reg global_irq_clear_o,
  output reg global_irq_set_o,
  output wire sleeping_o,
  output wire [1:0] sleep_mode_o
);

  // ----------------------------------------------------------
  // states
  // ----------------------------------------------------------
  localparam ST_BOOT = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_ENTRY = 3'h2;
  localparam ST_RETURN = 3'h3;
  localparam ST_SLEEP = 3'h4;

  reg [2:0] state_q;
  reg [2:0] cyc_q;
  reg [1:0] jmp_q;
  reg hold_one_q;
  reg [1:0] mode_q;
  reg [`VIS_IDX_W-1:0] sel_q;
  reg [7:0] pop_hi_q;
  reg [15:0] sp_base_q;
  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;
  reg [7:0] hw_clear_w;
  wire [7:0] flags_w;
  wire [`VIS_NUM_SLOTS-1:0] req_w;
  wire [15:0] arr_w;
  wire deep_w;
  wire pick_valid_w;
  wire [`VIS_IDX_W-1:0] pick_idx_w;
  wire take_w;
  wire [7:0] ten_w;

  // ----------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_irq_line_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------
  // timer flags
  // ----------------------------------------------------------
  vis_timer_flags u_tflags (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .t0_tick_i(t0_tick_i),
    .t0_count_i(t0_count_i),
    .compare_value_t0_i(compare_value_t0_i),
    .t0_overflow_i(t0_overflow_i),
    .t0_pwm_mode_i(t0_pwm_mode_i),
    .t2_tick_i(t2_tick_i),
    .t2_count_i(t2_count_i),
    .compare_value_t2_i(compare_value_t2_i),
    .t2_overflow_i(t2_overflow_i),
    .t1_capture_i(t1_capture_i),
    .t1_compare_a_i(t1_compare_a_i),
    .t1_compare_b_i(t1_compare_b_i),
    .t1_overflow_i(t1_overflow_i),
    .flag_write_i(flag_write_i),
    .flag_write_data_i(flag_write_data_i),
    .hw_clear_i(hw_clear_w),
    .flags_o(flags_w)
  );
  assign timer_flags_o = flags_w;

  // ----------------------------------------------------------
  // request slots
  // ----------------------------------------------------------
  // deep sleep modes
  assign deep_w = (state_q == ST_SLEEP) &&
                  ((mode_q == `VIS_SLP_PDOWN) || (mode_q == `VIS_SLP_PSAVE));

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_arr
      if (g < ARRAY_LINES) begin : g_on
        if (g < 4) begin : g_lvl
          // low level requests in deep sleep
          assign arr_w[g] = deep_w ? ~array_irq_line_i[g] : array_irq_line_i[g];
        end else begin : g_hi
          assign arr_w[g] = array_irq_line_i[g];
        end
      end else begin : g_off
        assign arr_w[g] = 1'b0;
      end
    end
    for (g = 0; g < 4; g = g + 1) begin : g_low
      // array n and pin n interleave
      assign req_w[`VIS_IDX_ARR0 + 2 * g] = arr_w[g];
      assign req_w[`VIS_IDX_ARR0 + 2 * g + 1] = deep_w ? ~pin_s2_q[g] : pin_s2_q[g];
      assign req_w[`VIS_IDX_ARR4 + g] = arr_w[g + 4];
      assign req_w[`VIS_IDX_ARR8 + g] = arr_w[g + 8];
      assign req_w[`VIS_IDX_ARR12 + g] = arr_w[g + 12];
    end
  endgenerate

  assign req_w[0] = 1'b0;
  assign ten_w = flags_w & timer_irq_enable_i;
  assign req_w[`VIS_IDX_T2_CMP] = ten_w[`VIS_TF_CMP_T2];
  assign req_w[`VIS_IDX_T2_OVF] = ten_w[`VIS_TF_OVF_T2];
  assign req_w[`VIS_IDX_T1_CAP] = ten_w[`VIS_TF_CAP_T1];
  assign req_w[`VIS_IDX_T1_CMPA] = ten_w[`VIS_TF_CMPA_T1];
  assign req_w[`VIS_IDX_T1_CMPB] = ten_w[`VIS_TF_CMPB_T1];
  assign req_w[`VIS_IDX_T1_OVF] = ten_w[`VIS_TF_OVF_T1];
  assign req_w[`VIS_IDX_T0_CMP] = ten_w[`VIS_TF_CMP_T0];
  assign req_w[`VIS_IDX_T0_OVF] = ten_w[`VIS_TF_OVF_T0];
  assign req_w[`VIS_IDX_SER0] = serial_rx_done_irq_i;
  assign req_w[`VIS_IDX_SER0 + 1] = serial_tx_empty_irq_i;
  assign req_w[`VIS_IDX_SER0 + 2] = serial_tx_done_irq_i;
  assign req_w[`VIS_IDX_SER1] = serial1_rx_done_irq_i;
  assign req_w[`VIS_IDX_SER1 + 1] = serial1_tx_empty_irq_i;
  assign req_w[`VIS_IDX_SER1 + 2] = serial1_tx_done_irq_i;
  assign req_w[`VIS_IDX_TWI] = two_wire_irq_i;

  vis_prio_enc #(
    .N(`VIS_NUM_SLOTS)
  ) u_prio (
    .req_i(req_w),
    .valid_o(pick_valid_w),
    .idx_o(pick_idx_w)
  );

  // ----------------------------------------------------------
  // take decision
  // ----------------------------------------------------------
  // global enable gates every source
  // only at an instruction end while running, or at once while asleep
  // one main instruction after a return
  assign take_w = pick_valid_w && global_irq_enable_i && (jmp_q == 2'h0) &&
                  (((state_q == ST_RUN) && instr_done_i && !hold_one_q) ||
                   (state_q == ST_SLEEP));

  always @* begin
    hw_clear_w = 8'h00;
    if (take_w) begin
      case (pick_idx_w)
        `VIS_IDX_T2_CMP: hw_clear_w[`VIS_TF_CMP_T2] = 1'b1;
        `VIS_IDX_T2_OVF: hw_clear_w[`VIS_TF_OVF_T2] = 1'b1;
        `VIS_IDX_T1_CAP: hw_clear_w[`VIS_TF_CAP_T1] = 1'b1;
        `VIS_IDX_T1_CMPA: hw_clear_w[`VIS_TF_CMPA_T1] = 1'b1;
        `VIS_IDX_T1_CMPB: hw_clear_w[`VIS_TF_CMPB_T1] = 1'b1;
        `VIS_IDX_T1_OVF: hw_clear_w[`VIS_TF_OVF_T1] = 1'b1;
        `VIS_IDX_T0_CMP: hw_clear_w[`VIS_TF_CMP_T0] = 1'b1;
        `VIS_IDX_T0_OVF: hw_clear_w[`VIS_TF_OVF_T0] = 1'b1;
        default: hw_clear_w = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_BOOT;
      cyc_q <= 3'h0;
      jmp_q <= 2'h0;
      hold_one_q <= 1'b0;
      mode_q <= `VIS_SLP_IDLE;
      sel_q <= {`VIS_IDX_W{1'b0}};
      pop_hi_q <= 8'h00;
      sp_base_q <= 16'h0000;
    end else begin
      if (jmp_q != 2'h0) begin
        jmp_q <= jmp_q - 2'h1;
      end
      if (instr_done_i) begin
        hold_one_q <= 1'b0;
      end
      case (state_q)
        ST_BOOT: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (take_w) begin
            state_q <= ST_ENTRY;
            cyc_q <= 3'h0;
            sel_q <= pick_idx_w;
            sp_base_q <= sp_i;
          end else if (reti_i) begin
            state_q <= ST_RETURN;
            cyc_q <= 3'h0;
            sp_base_q <= sp_i;
          // sleep needs permit and the instruction
          end else if (sleep_instr_i && sleep_permit_i) begin
            state_q <= ST_SLEEP;
            mode_q <= {sleep_select_hi_i, sleep_select_lo_i};
          end
        end
        ST_SLEEP: begin
          if (take_w) begin
            state_q <= ST_ENTRY;
            cyc_q <= 3'h0;
            sel_q <= pick_idx_w;
            sp_base_q <= sp_i;
          end
        end
        // four entry cycles, then the vector
        ST_ENTRY: begin
          cyc_q <= cyc_q + 3'h1;
          if (cyc_q == `VIS_ENTRY_CYC - 3'h1) begin
            state_q <= ST_RUN;
            jmp_q <= `VIS_JMP_CYC;
          end
        end
        ST_RETURN: begin
          cyc_q <= cyc_q + 3'h1;
          // read data stands the cycle after each strobe
          if (cyc_q == 3'h2) begin
            pop_hi_q <= stack_rdata_i;
          end
          if (cyc_q == `VIS_RETURN_CYC - 3'h1) begin
            state_q <= ST_RUN;
            // hold until one main instruction ends
            hold_one_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // stack, pc and sp strobes (registered)
  // ----------------------------------------------------------
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stack_we_o <= 1'b0;
      stack_re_o <= 1'b0;
      stack_addr_o <= 16'h0000;
      stack_wdata_o <= 8'h00;
      sp_load_o <= 1'b0;
      sp_o <= 16'h0000;
      pc_load_o <= 1'b0;
      pc_o <= `VIS_VEC_RESET;
      global_irq_clear_o <= 1'b0;
      global_irq_set_o <= 1'b0;
    end else begin
      stack_we_o <= 1'b0;
      stack_re_o <= 1'b0;
      sp_load_o <= 1'b0;
      pc_load_o <= 1'b0;
      global_irq_clear_o <= 1'b0;
      global_irq_set_o <= 1'b0;
      case (state_q)
        // execution starts at the reset vector
        ST_BOOT: begin
          pc_load_o <= 1'b1;
          pc_o <= `VIS_VEC_RESET;
        end
        // push low then high byte, sp down by two
        ST_ENTRY: begin
          case (cyc_q)
            3'h0: begin
              stack_we_o <= 1'b1;
              stack_addr_o <= sp_base_q;
              stack_wdata_o <= pc_i[7:0];
              global_irq_clear_o <= 1'b1;
            end
            3'h1: begin
              stack_we_o <= 1'b1;
              stack_addr_o <= sp_base_q - 16'h0001;
              stack_wdata_o <= pc_i[15:8];
            end
            3'h2: begin
              sp_load_o <= 1'b1;
              sp_o <= sp_base_q - 16'h0002;
            end
            default: begin
              pc_load_o <= 1'b1;
              pc_o <= {{(16 - `VIS_IDX_W - 1){1'b0}}, sel_q, 1'b0};
            end
          endcase
        end
        // pop high then low byte, sp up by two
        ST_RETURN: begin
          case (cyc_q)
            3'h0: begin
              stack_re_o <= 1'b1;
              stack_addr_o <= sp_base_q + 16'h0001;
            end
            3'h1: begin
              stack_re_o <= 1'b1;
              stack_addr_o <= sp_base_q + 16'h0002;
            end
            3'h2: begin
              sp_load_o <= 1'b1;
              sp_o <= sp_base_q + 16'h0002;
            end
            default: begin
              // resumes where the push left off
              pc_load_o <= 1'b1;
              pc_o <= {pop_hi_q, stack_rdata_i};
              global_irq_set_o <= 1'b1;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  // core stalls while the block owns the stack or sleeps
  assign core_hold_o = (state_q == ST_ENTRY) || (state_q == ST_RETURN) ||
                       (state_q == ST_SLEEP) || (state_q == ST_BOOT);
  assign sleeping_o = (state_q == ST_SLEEP);
  assign sleep_mode_o = mode_q;

endmodule // vis_dispatch
`default_nettype wire

// File: core/vis_prio_enc.v
/*
  Priority encoder: the lowest set slot wins.
  Assumes slot 0 is never requested.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vis_defines.vh"

module vis_prio_enc #(
  parameter N = `VIS_NUM_SLOTS
) (
  input wire [N-1:0] req_i,
  output wire valid_o,
  output wire [`VIS_IDX_W-1:0] idx_o
);

  function [`VIS_IDX_W-1:0] lowest;
    input [N-1:0] v;
    integer k;
    begin
      lowest = {`VIS_IDX_W{1'b0}};
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest = k[`VIS_IDX_W-1:0];
        end
      end
    end
  endfunction

  assign idx_o = lowest(req_i);
  assign valid_o = |req_i;

endmodule // vis_prio_enc
`default_nettype wire

// File: core/vis_timer_flags.v
/*
  Timer flags: set by events, cleared on vector entry or write of one.
  Assumes events and counts on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vis_defines.vh"

module vis_timer_flags (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire t0_tick_i,
  input wire [7:0] t0_count_i,
  input wire [7:0] compare_value_t0_i,
  input wire t0_overflow_i,
  input wire t0_pwm_mode_i,
  input wire t2_tick_i,
  input wire [7:0] t2_count_i,
  input wire [7:0] compare_value_t2_i,
  input wire t2_overflow_i,
  input wire t1_capture_i,
  input wire t1_compare_a_i,
  input wire t1_compare_b_i,
  input wire t1_overflow_i,
  input wire flag_write_i,
  input wire [7:0] flag_write_data_i,
  input wire [7:0] hw_clear_i,
  output wire [7:0] flags_o
);

  reg [7:0] flags_q;
  reg [7:0] t0_prev_q;
  reg [7:0] set_w;
  wire [7:0] clr_w;

  // t0 count before the current tick, for the pwm rule
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t0_prev_q <= 8'h00;
    end else if (t0_tick_i) begin
      t0_prev_q <= t0_count_i;
    end
  end

  always @* begin
    set_w = 8'h00;
    set_w[`VIS_TF_CMP_T0] = t0_tick_i && (t0_count_i == compare_value_t0_i);
    // overflow, or leaving zero in pwm
    set_w[`VIS_TF_OVF_T0] = t0_pwm_mode_i ?
      (t0_tick_i && (t0_prev_q == `VIS_COUNT_ZERO) && (t0_count_i != `VIS_COUNT_ZERO)) :
      t0_overflow_i;
    set_w[`VIS_TF_CMP_T2] = t2_tick_i && (t2_count_i == compare_value_t2_i);
    set_w[`VIS_TF_CAP_T1] = t1_capture_i;
    set_w[`VIS_TF_OVF_T2] = t2_overflow_i;
    set_w[`VIS_TF_CMPA_T1] = t1_compare_a_i;
    set_w[`VIS_TF_CMPB_T1] = t1_compare_b_i;
    set_w[`VIS_TF_OVF_T1] = t1_overflow_i;
  end

  assign clr_w = hw_clear_i | (flag_write_i ? flag_write_data_i : 8'h00);

  // a set in the clearing cycle wins, so no event is lost
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (flags_q & ~clr_w) | set_w;
    end
  end

  assign flags_o = flags_q;

endmodule // vis_timer_flags
`default_nettype wire

// File: verification/vis_dispatch_monitor.sv
/*
  Checker: entry, return, sleep and timer flags.
  Assumes binding onto vis_dispatch, ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_dispatch_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sleep_permit_i,
  input wire logic sleep_select_hi_i,
  input wire logic sleep_select_lo_i,
  input wire logic sleep_instr_i,
  input wire logic t1_capture_i,
  input wire logic flag_write_i,
  input wire logic [7:0] flag_write_data_i,
  input wire logic [7:0] timer_flags_o,
  input wire logic core_hold_o,
  input wire logic stack_we_o,
  input wire logic stack_re_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic sp_load_o,
  input wire logic [15:0] sp_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_o,
  input wire logic global_irq_clear_o,
  input wire logic global_irq_set_o,
  input wire logic sleeping_o,
  input wire logic [1:0] sleep_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------------------------
  // entry and return sequences
  // ----------------------------------------------------------
  chk_push_then_vector: assert property (
    stack_we_o && !$past(stack_we_o) |=> (stack_we_o && stack_addr_o == $past(stack_addr_o) - 16'h0001)
    ##1 (sp_load_o && sp_o == $past(stack_addr_o, 2) - 16'h0002) ##1 pc_load_o) else $error("push sequence wrong");
  chk_vector_in_map: assert property (
    pc_load_o && $past(stack_we_o, 2) |-> !pc_o[0] && pc_o >= 16'h0002 && pc_o <= 16'h0046)
    else $error("vector outside the map");
  chk_clear_with_push: assert property (
    global_irq_clear_o |-> stack_we_o && !$past(stack_we_o)) else $error("global clear out of place");
  chk_hold_over_entry: assert property (
    $rose(stack_we_o) |-> core_hold_o [*3] ##1 !core_hold_o) else $error("core hold span wrong");
  chk_pop_then_load: assert property (
    stack_re_o && !$past(stack_re_o) |=> (stack_re_o && stack_addr_o == $past(stack_addr_o) + 16'h0001)
    ##1 (sp_load_o && sp_o == $past(stack_addr_o)) ##1 (pc_load_o && global_irq_set_o))
    else $error("pop sequence wrong");
  // ----------------------------------------------------------
  // sleep and flags
  // ----------------------------------------------------------
  chk_sleep_needs_permit: assert property (
    !core_hold_o && sleep_instr_i && !sleep_permit_i |=> !sleeping_o) else $error("slept without permit");
  chk_sleep_mode_latch: assert property (
    $rose(sleeping_o) |-> sleep_mode_o == {$past(sleep_select_hi_i), $past(sleep_select_lo_i)})
    else $error("sleep mode not latched");
  chk_sleep_stalls_core: assert property (
    sleeping_o |-> core_hold_o) else $error("core runs while asleep");
  chk_capture_flag_set: assert property (
    t1_capture_i |=> timer_flags_o[3]) else $error("capture flag not set");
  chk_flag_write_clear: assert property (
    flag_write_i && flag_write_data_i[3] && !t1_capture_i |=> !timer_flags_o[3]) else $error("flag not cleared");
endmodule // vis_dispatch_monitor

bind vis_dispatch vis_dispatch_monitor i_monitor (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .sleep_permit_i(sleep_permit_i), .sleep_select_hi_i(sleep_select_hi_i), .sleep_select_lo_i(sleep_select_lo_i),
  .sleep_instr_i(sleep_instr_i), .t1_capture_i(t1_capture_i), .flag_write_i(flag_write_i),
  .flag_write_data_i(flag_write_data_i), .timer_flags_o(timer_flags_o), .core_hold_o(core_hold_o),
  .stack_we_o(stack_we_o), .stack_re_o(stack_re_o), .stack_addr_o(stack_addr_o), .sp_load_o(sp_load_o),
  .sp_o(sp_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .global_irq_clear_o(global_irq_clear_o),
  .global_irq_set_o(global_irq_set_o), .sleeping_o(sleeping_o), .sleep_mode_o(sleep_mode_o));
`default_nettype wire

// File: verification/vis_dispatch_tb_top.sv
/*
  Bench for vis_dispatch: vectors, flags, gating, priority, sleep.
  Assumes the stack model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_dispatch_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic gie = 1'b0, instr_done = 1'b0, reti = 1'b0, slp = 1'b0, permit = 1'b0, fw = 1'b0, pwm = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [35:0] src = '0;
  logic [7:0] tev = 8'h00, ten = 8'hFF, fwd = 8'h00, cnt = 8'h5A, cmp = 8'h5A;
  logic [15:0] sp = 16'h0FF0, pc = 16'h0100, spv;
  wire we, re, sp_load, pc_load, sleeping;
  wire [1:0] sleep_mode;
  wire [7:0] flags, rdata, wdata;
  wire [15:0] addr, sp_o, pc_o;
  int errors = 0, compares = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  // core sp follows loads
  always @(posedge sys_clk_i) if (sp_load === 1'b1) sp <= sp_o;
  // slot s of src is the source whose vector sits at twice s
  vis_dispatch i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .global_irq_enable_i(gie),
    .array_irq_line_i({src[34:31], src[27:24], src[20:17], src[7], src[5], src[3], src[1]}),
    .pin_irq_line_i({src[8], src[6], src[4], src[2]}), .serial_rx_done_irq_i(src[21]),
    .serial_tx_empty_irq_i(src[22]), .serial_tx_done_irq_i(src[23]), .serial1_rx_done_irq_i(src[28]),
    .serial1_tx_empty_irq_i(src[29]), .serial1_tx_done_irq_i(src[30]), .two_wire_irq_i(src[35]),
    .timer_irq_enable_i(ten), .t0_tick_i(tev[0]), .t0_count_i(cnt), .compare_value_t0_i(cmp),
    .t0_overflow_i(tev[1]), .t0_pwm_mode_i(pwm), .t2_tick_i(tev[2]), .t2_count_i(cnt), .compare_value_t2_i(cmp),
    .t2_overflow_i(tev[4]), .t1_capture_i(tev[3]), .t1_compare_a_i(tev[5]), .t1_compare_b_i(tev[6]),
    .t1_overflow_i(tev[7]), .flag_write_i(fw), .flag_write_data_i(fwd), .sleep_permit_i(permit),
    .sleep_select_hi_i(sel[1]), .sleep_select_lo_i(sel[0]), .instr_done_i(instr_done), .reti_i(reti),
    .sleep_instr_i(slp), .pc_i(pc), .sp_i(sp), .stack_rdata_i(rdata), .timer_flags_o(flags), .core_hold_o(),
    .stack_we_o(we), .stack_re_o(re), .stack_addr_o(addr), .stack_wdata_o(wdata), .sp_load_o(sp_load),
    .sp_o(sp_o), .pc_load_o(pc_load), .pc_o(pc_o), .global_irq_clear_o(), .global_irq_set_o(),
    .sleeping_o(sleeping), .sleep_mode_o(sleep_mode));
  vis_stack_model i_stack (.sys_clk_i(sys_clk_i), .we_i(we), .re_i(re), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic cyc;
    @(posedge sys_clk_i);
    #2;
  endtask
  task automatic complete_run;
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wait_load(input logic [15:0] exp);
    int n;
    for (n = 0; n < 20 && pc_load !== 1'b1; n++) begin
      cyc;
      if (sp_load === 1'b1) spv = sp_o;
    end
    if (n == 20) begin
      check16(16'h0000, 16'h0001, "no program counter load");
      complete_run;
    end
    check16(pc_o, exp, "loaded program counter");
  endtask
  task automatic ret_check;
    repeat (4) cyc;
    reti = 1'b1;
    cyc;
    reti = 1'b0;
    wait_load(pc);
    check16(spv, 16'h0FF0, "stack pointer after pop");
  endtask
  task automatic serve(input logic [15:0] vec, input logic [35:0] drop);
    pc = pc + 16'h0102;
    repeat (4) cyc;
    instr_done = 1'b1;
    repeat (2) cyc;
    instr_done = 1'b0;
    wait_load(vec);
    check16(spv, 16'h0FEE, "stack pointer after push");
    src = src & ~drop;
    ret_check;
  endtask
  task automatic no_take(input logic done);
    logic seen;
    seen = 1'b0;
    instr_done = done;
    repeat (10) begin
      cyc;
      instr_done = 1'b0;
      seen = seen | pc_load;
    end
    check16(16'(seen), 16'h0000, "request taken while refused");
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_vectors;
    for (int s = 1; s < 36; s++) begin
      if (s < 9 || s > 16) begin
        src[s] = 1'b1;
        serve(16'(2 * s), 36'h1 << s);
      end
    end
  endtask
  task automatic t_timers;
    logic [15:0] vec [8] = '{16'h001E, 16'h0020, 16'h0012, 16'h0016, 16'h0014, 16'h0018, 16'h001A, 16'h001C};
    for (int i = 0; i < 8; i++) begin
      tev[i] = 1'b1;
      cyc;
      tev = 8'h00;
      cyc;
      check16(16'(flags), 16'(1 << i), "flag after event");
      serve(vec[i], '0);
      check16(16'(flags), 16'h0000, "flag after vector");
    end
    pwm = 1'b1;
    cnt = 8'h00;
    tev[0] = 1'b1;
    cyc;
    cnt = 8'h01;
    cyc;
    tev = 8'h00;
    pwm = 1'b0;
    cnt = 8'h5A;
    cyc;
    check16(16'(flags), 16'h0002, "pwm overflow flag");
    serve(16'h0020, '0);
  endtask
  task automatic nap(input logic [1:0] m, input logic [15:0] exp);
    sel = m;
    slp = 1'b1;
    cyc;
    slp = 1'b0;
    cyc;
    check16(16'({sleeping, sleep_mode}), exp, "sleep state");
  endtask
  task automatic t_gating;
    ten = 8'hF7;
    tev[3] = 1'b1;
    cyc;
    tev = 8'h00;
    no_take(1'b1);
    ten = 8'hFF;
    gie = 1'b0;
    no_take(1'b1);
    fwd = 8'h08;
    fw = 1'b1;
    cyc;
    fw = 1'b0;
    cyc;
    check16(16'(flags), 16'h0000, "flag after write of one");
    gie = 1'b1;
  endtask
  task automatic t_priority;
    src[5] = 1'b1;
    src[3] = 1'b1;
    serve(16'h0006, 36'h8);
    no_take(1'b1);
    serve(16'h000A, 36'h20);
  endtask
  task automatic t_sleep;
    gie = 1'b0;
    nap(2'h2, 16'h0000);
    permit = 1'b1;
    for (int m = 2; m < 4; m++) begin
      gie = 1'b0;
      src[8:1] = 8'hFF;
      repeat (4) cyc;
      nap(2'(m), 16'(4 + m));
      gie = 1'b1;
      src[3 * m - 1] = 1'b0;
      wait_load(16'(6 * m - 2));
      src = '0;
      check16(16'(sleeping), 16'h0000, "awake after interrupt");
      ret_check;
    end
    nap(2'h0, 16'h0004);
    reset_n_i = 1'b0;
    cyc;
    check16(16'(sleeping), 16'h0000, "reset ends sleep");
    reset_n_i = 1'b1;
    wait_load(16'h0000);
  endtask
  initial begin
    repeat (10) cyc;
    reset_n_i = 1'b1;
    wait_load(16'h0000);
    gie = 1'b1;
    t_vectors;
    t_timers;
    t_gating;
    t_priority;
    t_sleep;
    complete_run;
  end
endmodule // vis_dispatch_tb_top
`default_nettype wire

// File: verification/vis_stack_model.sv
/*
  Far-side model: the core's stack memory answering push and pop strobes.
  Assumes read data is wanted one cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module vis_stack_model (
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output var logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:255];
  initial rdata_o = 8'hA5;
  // data lines wander outside a read, so a late sample cannot pass by luck
  always @(posedge sys_clk_i) begin
    if (we_i) mem_q[addr_i[7:0]] <= wdata_i;
    rdata_o <= re_i ? mem_q[addr_i[7:0]] : ~rdata_o;
  end
endmodule // vis_stack_model
`default_nettype wire
